// ---- shared/com_consts.vh ----
/*
 * Constants of the OR / move / multiply execution core: opcode patterns,
 * address map constants, phase codes and the APB register map.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef COM_CONSTS_VH
`define COM_CONSTS_VH

// ==========================================================
// Instruction phases within one instruction cycle
`define COM_Q1 2'h0
`define COM_Q2 2'h1
`define COM_Q3 2'h2
`define COM_Q4 2'h3

// ==========================================================
// Opcode patterns
`define COM_OP_ORLIT 8'h09
`define COM_OP_LOAD_WORKING_LITERAL_OP 8'h0E
`define COM_OP_MULLIT 8'h0D
`define COM_OP_LDBANK 8'h01
`define COM_OP_ORFILE 6'h04
`define COM_OP_MOVFILE 6'h14
`define COM_OP_STOREW 7'h37
`define COM_OP_LDPTR 10'h3B8
`define COM_OP_FF_SRC 4'hC
`define COM_OP_FF_DST 4'hF
`define COM_PTR_COUNT 2'h3

// ==========================================================
// Data space
`define COM_ACC_LIMIT 8'h5F
`define COM_ACC_HIGH_BANK 4'hF
`define COM_WREG_ADDR 12'hFFF

// ==========================================================
// APB register byte offsets
`define COM_REG_CTRL 8'h00
`define COM_REG_WORK 8'h04
`define COM_REG_FLAGS 8'h08
`define COM_REG_BANK 8'h0C
`define COM_REG_PROD 8'h10
`define COM_REG_PTR0 8'h14
`define COM_REG_PTR1 8'h18
`define COM_REG_PTR2 8'h1C
`define COM_REG_PC 8'h20
`define COM_REG_CORE 8'h24

// ==========================================================
// Field positions
`define COM_CTRL_RUN 0
`define COM_CTRL_EXT 1
`define COM_FLAG_N 4
`define COM_FLAG_Z 2
`define COM_CORE_BADOP 0

`endif

// ---- src/com_core.v ----
/*
 * Execution core for the OR, move, pointer/bank load and literal multiply
 * instructions, with an APB slave for control and observation.
 * Assumes program and data memories on mclk that answer combinationally
 * to the address outputs; W is mapped into data space at one address.
 */
// Operation
// - OR literal into W, update N and Z
// - OR file with W, update only N, Z
// - Direction 0 to W, 1 to file
// - Bank bit 0 access bank, 1 uses bank
// - Extended set, f<=95: indexed pointer-2 offset
// - Pointer load: two words, high then low
// - Move file to destination, update N, Z
// - Full bank reach; store W keeps flags
// - Two-word file-to-file move, 12-bit addresses
// - Bank load clears upper four bits
// - Load literal into W, flags kept
// - Unsigned 8x8 product into product pair
// - Multiply never touches any flag
`default_nettype none
`include "com_consts.vh"

module com_core #(
    parameter PC_W = 16
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Program memory
    output reg [PC_W-1:0] progAddr,
    input wire [15:0] progData,
    // Data memory
    output reg [11:0] dmAddr,
    output reg dmRd,
    output reg dmWe,
    output reg [7:0] dmWrData,
    input wire [7:0] dmRdData,
    input wire dmWait
);

    // ==========================================================
    // Sequencer states
    localparam [1:0] ST_FIRST = 2'h0;
    localparam [1:0] ST_PTR2 = 2'h1;
    localparam [1:0] ST_FF2 = 2'h2;
    localparam [1:0] ST_STALL = 2'h3;

    reg [1:0] qPhase_q;
    reg [1:0] state_q;
    reg [15:0] ir_q;
    reg [7:0] opnd_q;
    reg [7:0] work_q;
    reg [4:0] flags_q;
    reg [3:0] bank_q;
    reg [15:0] prod_q;
    reg run_q;
    reg ext_q;
    reg badOp_q;
    reg [1:0] ptrSel_q;
    wire [11:0] ptr0;
    wire [11:0] ptr1;
    wire [11:0] ptr2;

    // ==========================================================
    // Control and APB strobes
    wire running = run_q | (qPhase_q != `COM_Q1) | (state_q != ST_FIRST);
    wire commit = running & (qPhase_q == `COM_Q4);
    wire apbWr = psel & penable & pready & pwrite;
    wire apbIdle = apbWr & ~running;

    // ==========================================================
    // Class decode of the latched instruction word
    wire first = (state_q == ST_FIRST);
    wire isOrL = first & (ir_q[15:8] == `COM_OP_ORLIT);
    wire isMovLw = first & (ir_q[15:8] == `COM_OP_LOAD_WORKING_LITERAL_OP);
    wire isMul = first & (ir_q[15:8] == `COM_OP_MULLIT);
    wire isLdBank = first & (ir_q[15:8] == `COM_OP_LDBANK);
    wire isOrF = first & (ir_q[15:10] == `COM_OP_ORFILE);
    wire isMovF = first & (ir_q[15:10] == `COM_OP_MOVFILE);
    wire isStoreW = first & (ir_q[15:9] == `COM_OP_STOREW);
    wire isLdPtr = first & (ir_q[15:6] == `COM_OP_LDPTR) & (ir_q[5:4] < `COM_PTR_COUNT);
    wire isFf = first & (ir_q[15:12] == `COM_OP_FF_SRC);
    wire known = isOrL | isMovLw | isMul | isLdBank | isOrF | isMovF | isStoreW
        | isLdPtr | isFf;
    wire dirBit = ir_q[9];

    // Destination selection
    wire wrFile = ((isOrF | isMovF) & dirBit) | isStoreW | (state_q == ST_FF2);
    wire wrWork = isOrL | isMovLw | ((isOrF | isMovF) & ~dirBit);
    wire fileIsW = (dmAddr == `COM_WREG_ADDR);
    wire setNZ = isOrL | isOrF | isMovF;

    // ==========================================================
    // Q1 decode of the fetched word for the operand address
    wire pdFf = (state_q == ST_FIRST) & (progData[15:12] == `COM_OP_FF_SRC);
    wire pdFile = (state_q == ST_FIRST) & ((progData[15:10] == `COM_OP_ORFILE)
        | (progData[15:10] == `COM_OP_MOVFILE) | (progData[15:9] == `COM_OP_STOREW));
    wire [7:0] pdF = progData[7:0];
    wire pdIdx = ~progData[8] & ext_q & (pdF <= `COM_ACC_LIMIT);
    reg [11:0] pdAddr;

    // Data address formation for byte operations
    always @* begin
        if (pdFf) begin
            pdAddr = progData[11:0];
        end else if (progData[8]) begin
            pdAddr = {bank_q, pdF};
        end else if (pdIdx) begin
            pdAddr = ptr2 + {4'h0, pdF};
        end else if (pdF <= `COM_ACC_LIMIT) begin
            pdAddr = {4'h0, pdF};
        end else begin
            pdAddr = {`COM_ACC_HIGH_BANK, pdF};
        end
    end

    // ==========================================================
    // Q3 result computation
    reg [7:0] result;
    always @* begin
        if (isOrL) begin
            result = work_q | opnd_q;
        end else if (isOrF) begin
            result = work_q | opnd_q;
        end else if (isStoreW) begin
            result = work_q;
        end else begin
            result = opnd_q;
        end
    end
    wire [15:0] product = {8'h00, work_q} * {8'h00, opnd_q};

    // ==========================================================
    // Sequencer, architectural registers and memory strobes
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            qPhase_q <= `COM_Q1;
            state_q <= ST_FIRST;
            ir_q <= 16'h0000;
            opnd_q <= 8'h00;
            work_q <= 8'h00;
            flags_q <= 5'h00;
            bank_q <= 4'h0;
            prod_q <= 16'h0000;
            run_q <= 1'b0;
            ext_q <= 1'b0;
            badOp_q <= 1'b0;
            ptrSel_q <= 2'h0;
            progAddr <= {PC_W{1'b0}};
            dmAddr <= 12'h000;
            dmRd <= 1'b0;
            dmWe <= 1'b0;
            dmWrData <= 8'h00;
        end else begin
            // Control register writes at any time
            if (apbWr && paddr == `COM_REG_CTRL) begin
                run_q <= pwdata[`COM_CTRL_RUN];
                ext_q <= pwdata[`COM_CTRL_EXT];
            end
            // Architectural writes from APB only while stopped
            if (apbIdle && paddr == `COM_REG_WORK) begin
                work_q <= pwdata[7:0];
            end
            if (apbIdle && paddr == `COM_REG_FLAGS) begin
                flags_q <= pwdata[4:0];
            end
            if (apbIdle && paddr == `COM_REG_BANK) begin
                bank_q <= pwdata[3:0];
            end
            if (apbIdle && paddr == `COM_REG_PC) begin
                progAddr <= pwdata[PC_W-1:0];
            end
            // Unknown opcode flag, set wins over clear
            if (commit && first && !known) begin
                badOp_q <= 1'b1;
            end else if (apbWr && paddr == `COM_REG_CORE && pwdata[`COM_CORE_BADOP]) begin
                badOp_q <= 1'b0;
            end
            if (running) begin
                qPhase_q <= qPhase_q + 2'h1;
                case (qPhase_q)
                    `COM_Q1: begin
                        // Decode: latch word, present operand address
                        if (state_q != ST_STALL) begin
                            ir_q <= progData;
                        end
                        if (state_q == ST_FF2) begin
                            dmAddr <= progData[11:0];
                        end else if (state_q == ST_FIRST) begin
                            dmAddr <= pdAddr;
                            dmRd <= pdFile | pdFf;
                        end
                    end
                    `COM_Q2: begin
                        // Read operand or literal
                        dmRd <= 1'b0;
                        if (isFf || (first && (isOrF || isMovF || isStoreW))) begin
                            opnd_q <= fileIsW ? work_q : dmRdData;
                        end else if (first) begin
                            opnd_q <= ir_q[7:0];
                        end
                    end
                    `COM_Q3: begin
                        // Process and raise the data write
                        dmWrData <= result;
                        if (state_q != ST_STALL) begin
                            dmWe <= wrFile & ~fileIsW;
                        end
                    end
                    default: begin
                        // Write destination and advance
                        if ((wrWork || (wrFile && fileIsW)) && state_q != ST_STALL) begin
                            work_q <= result;
                        end
                        if (setNZ) begin
                            flags_q[`COM_FLAG_N] <= result[7];
                            flags_q[`COM_FLAG_Z] <= (result == 8'h00);
                        end
                        if (isMul) begin
                            prod_q <= product;
                        end
                        if (isLdBank) begin
                            bank_q <= ir_q[3:0];
                        end
                        if (isLdPtr) begin
                            ptrSel_q <= ir_q[5:4];
                        end
                        if (state_q == ST_FF2 && dmWe && dmWait) begin
                            state_q <= ST_STALL;
                        end else begin
                            dmWe <= 1'b0;
                            progAddr <= progAddr + {{(PC_W-1){1'b0}}, 1'b1};
                            if (isLdPtr) begin
                                state_q <= ST_PTR2;
                            end else if (isFf) begin
                                state_q <= ST_FF2;
                            end else begin
                                state_q <= ST_FIRST;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Pointer registers, one per entry
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : gPtr
            localparam integer IDX = gi;
            reg [11:0] val_q;
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    val_q <= 12'h000;
                end else if (commit && isLdPtr && ir_q[5:4] == IDX[1:0]) begin
                    val_q[11:8] <= ir_q[3:0];
                end else if (commit && state_q == ST_PTR2 && ptrSel_q == IDX[1:0]) begin
                    val_q[7:0] <= ir_q[7:0];
                end
            end
        end
    endgenerate
    assign ptr0 = gPtr[0].val_q;
    assign ptr1 = gPtr[1].val_q;
    assign ptr2 = gPtr[2].val_q;

    // ==========================================================
    // APB read mux
    reg [31:0] rdMux;
    reg rdHit;
    always @* begin
        rdHit = 1'b1;
        case (paddr)
            `COM_REG_CTRL: rdMux = {30'h0, ext_q, run_q};
            `COM_REG_WORK: rdMux = {24'h0, work_q};
            `COM_REG_FLAGS: rdMux = {27'h0, flags_q};
            `COM_REG_BANK: rdMux = {28'h0, bank_q};
            `COM_REG_PROD: rdMux = {16'h0, prod_q};
            `COM_REG_PTR0: rdMux = {20'h0, ptr0};
            `COM_REG_PTR1: rdMux = {20'h0, ptr1};
            `COM_REG_PTR2: rdMux = {20'h0, ptr2};
            `COM_REG_PC: rdMux = {{(32-PC_W){1'b0}}, progAddr};
            `COM_REG_CORE: rdMux = {26'h0, qPhase_q, state_q, running, badOp_q};
            default: begin
                rdMux = 32'h0000_0000;
                rdHit = 1'b0;
            end
        endcase
    end

    // APB answer: ready one cycle after setup, data latched at setup
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~rdHit;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rdMux;
            end
        end
    end

endmodule // com_core
`default_nettype wire

// ---- verif/com_mem_model.sv ----
/* Program and data memory model facing com_core.
   Assumes one clock; the bench loads words and bytes directly. */
`default_nettype none
module com_mem_model (
    // Clock
    input wire logic mclk,
    // Program side
    input wire logic [15:0] progAddr,
    output logic [15:0] progData,
    // Data side
    input wire logic [11:0] dmAddr,
    input wire logic dmRd,
    input wire logic dmWe,
    input wire logic [7:0] dmWrData,
    output logic [7:0] dmRdData,
    output logic dmWait,
    // Scenario control
    input wire logic stallEn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] prog [0:255];
    logic [7:0] dmem [0:4095];
    logic stallSeen_q = 1'b0;
    // ==========
    // Memory contents start cleared
    initial begin
        for (int i = 0; i < 4096; i++) dmem[i] = 8'h00;
        for (int i = 0; i < 256; i++) prog[i] = 16'h0000;
    end
    // Words answer at once; unread data line shows the inverse
    assign progData = prog[progAddr[7:0]];
    assign dmRdData = dmRd ? dmem[dmAddr] : ~dmem[dmAddr];
    // One stalled write per enable, then the write lands
    assign dmWait = stallEn & ~stallSeen_q;
    always @(posedge mclk) begin
        stallSeen_q <= stallEn & (stallSeen_q | dmWe);
        if (dmWe && !dmWait) dmem[dmAddr] <= dmWrData;
    end
endmodule // com_mem_model
`default_nettype wire

// ---- verif/com_core_checker.sv ----
/* Port checker for com_core.
   Assumes one clock domain and the bind at the foot. */
`default_nettype none
module com_core_checker #(
    parameter PC_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Memories
    input wire logic [PC_W-1:0] progAddr,
    input wire logic [15:0] progData,
    input wire logic [11:0] dmAddr,
    input wire logic dmRd,
    input wire logic dmWe,
    input wire logic dmWait
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ==========
    // Steps of a stalled write and of a quiet cycle
    sequence stallTail;
        dmWe [*4] ##1 !dmWe;
    endsequence
    sequence noRead;
        !dmRd [*4];
    endsequence
    // ==========
    // Bus and core timing
    chk_bus_answer: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    chk_err_map: assert property (pready |-> (pslverr == ((paddr > 8'h24) || (paddr[1:0] != 2'h0))))
        else $error("wrong error response");
    chk_read_once: assert property (dmRd |=> !dmRd [*3])
        else $error("second read in a cycle");
    chk_write_pulse: assert property ($rose(dmWe) && !dmWait |=> !dmWe)
        else $error("write strobe too long");
    chk_write_noread: assert property (dmWe |-> !dmRd)
        else $error("read during write");
    chk_stall_tail: assert property (dmWe && dmWait |=> stallTail)
        else $error("bad stall cycle");
    chk_move_noread: assert property ($changed(progAddr) && progData[15:12] == 4'hF
        |-> noRead)
        else $error("dummy read in second word");
    chk_cycle_four: assert property ($changed(progAddr) |=> $stable(progAddr) [*3])
        else $error("cycle shorter than four");
    chk_work_nowrite: assert property (dmWe |-> dmAddr != 12'hFFF)
        else $error("memory write to work address");
endmodule // com_core_checker
bind com_core com_core_checker #(.PC_W(PC_W)) chk_i (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .progAddr(progAddr), .progData(progData),
    .dmAddr(dmAddr), .dmRd(dmRd), .dmWe(dmWe), .dmWait(dmWait));
`default_nettype wire

// ---- verif/com_testbench.sv ----
/* Self-checking bench for com_core.
   Assumes com_mem_model as memories and the bound checker. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic stallEn = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, dmRd, dmWe, dmWait;
    wire [15:0] progAddr, progData;
    wire [11:0] dmAddr;
    wire [7:0] dmWrData, dmRdData;
    int mismatches = 0;
    int checksDone = 0;
    logic lastErr = 1'b0;
    // ==========
    // Clock and instances
    always #12.5 mclk = ~mclk;
    com_core com_core_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .progAddr(progAddr), .progData(progData), .dmAddr(dmAddr),
        .dmRd(dmRd), .dmWe(dmWe), .dmWrData(dmWrData), .dmRdData(dmRdData), .dmWait(dmWait));
    com_mem_model com_mem_model_i (.mclk(mclk), .progAddr(progAddr), .progData(progData),
        .dmAddr(dmAddr), .dmRd(dmRd), .dmWe(dmWe), .dmWrData(dmWrData),
        .dmRdData(dmRdData), .dmWait(dmWait), .stallEn(stallEn));
    // ==========
    // Reporting
    task automatic wrap_up();
        if (mismatches == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic fail(input string m);
        mismatches++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) fail($sformatf("got %h want %h", got, exp));
    endtask
    // ==========
    // Bus master
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail("bus timeout");
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    // Runs words 0..last, stops at a boundary, clears the program
    task automatic run_prog(input logic [31:0] ctrl, input int last);
        logic [31:0] q;
        int n;
        wr(8'h20, 32'h0);
        wr(8'h00, ctrl);
        n = 0;
        while (progAddr <= last && n < 400) begin
            @(posedge mclk);
            n++;
        end
        wr(8'h00, 32'h0);
        q = 32'h2;
        while (q[1] && n < 420) begin
            apb(1'b0, 8'h24, 32'h0, q);
            n++;
        end
        if (n >= 400) begin
            fail("core timeout");
            wrap_up();
        end
        for (int i = 0; i < 16; i++) com_mem_model_i.prog[i] = 16'h0000;
    endtask
    // ==========
    // Scenarios
    task automatic sc_bus();
        expect_reg(8'h40, 32'h0);
        check({31'h0, lastErr}, 32'h1);
        wr(8'h14, 32'hFFF);
        check({31'h0, lastErr}, 32'h0);
        expect_reg(8'h14, 32'h0);
        wr(8'h04, 32'h5A);
        expect_reg(8'h04, 32'h5A);
    endtask
    task automatic sc_literal();
        com_mem_model_i.prog[0] = 16'h0E9A;
        com_mem_model_i.prog[1] = 16'h0935;
        com_mem_model_i.prog[2] = 16'h0E00;
        com_mem_model_i.prog[3] = 16'h0D37;
        com_mem_model_i.prog[4] = 16'h0195;
        run_prog(32'h1, 4);
        expect_reg(8'h04, 32'h00);
        expect_reg(8'h08, 32'h10);
        expect_reg(8'h10, 32'h0000);
        expect_reg(8'h0C, 32'h05);
    endtask
    task automatic sc_multiply();
        com_mem_model_i.prog[0] = 16'h0EE2;
        com_mem_model_i.prog[1] = 16'h0DC4;
        run_prog(32'h1, 1);
        expect_reg(8'h10, 32'hAD08);
        expect_reg(8'h04, 32'hE2);
    endtask
    task automatic sc_file();
        com_mem_model_i.dmem[12'h213] = 8'h13;
        com_mem_model_i.dmem[12'hF60] = 8'h04;
        com_mem_model_i.dmem[12'h2FF] = 8'hAA;
        com_mem_model_i.prog[0] = 16'h0E91;
        com_mem_model_i.prog[1] = 16'h0102;
        com_mem_model_i.prog[2] = 16'h1113;
        com_mem_model_i.prog[3] = 16'h1260;
        com_mem_model_i.prog[4] = 16'h5010;
        com_mem_model_i.prog[5] = 16'h6FFF;
        run_prog(32'h1, 5);
        check(com_mem_model_i.dmem[12'hF60], 32'h97);
        check(com_mem_model_i.dmem[12'h213], 32'h13);
        check(com_mem_model_i.dmem[12'h2FF], 32'h00);
        expect_reg(8'h04, 32'h00);
        expect_reg(8'h08, 32'h04);
    endtask
    // Destinations avoid counter and stack bytes
    task automatic sc_ext();
        stallEn <= 1'b1;
        com_mem_model_i.dmem[12'h3B0] = 8'hC5;
        com_mem_model_i.prog[0] = 16'hEE23;
        com_mem_model_i.prog[1] = 16'h00AB;
        com_mem_model_i.prog[2] = 16'h5005;
        com_mem_model_i.prog[3] = 16'hC3B0;
        com_mem_model_i.prog[4] = 16'hF123;
        com_mem_model_i.prog[5] = 16'hC213;
        com_mem_model_i.prog[6] = 16'hFFFF;
        run_prog(32'h3, 6);
        stallEn <= 1'b0;
        expect_reg(8'h1C, 32'h3AB);
        check(com_mem_model_i.dmem[12'h123], 32'hC5);
        expect_reg(8'h04, 32'h13);
        expect_reg(8'h08, 32'h10);
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        sc_bus();
        sc_literal();
        sc_multiply();
        sc_file();
        sc_ext();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
